/* verilog/dmmcc_pkg.sv */
package dmmcc_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned STROBE_HZ = 768;
    localparam int unsigned STROBE_STAGES = 320;
    localparam int unsigned OSC_DIV = CLK_HZ / (STROBE_HZ * STROBE_STAGES);
    localparam int unsigned PRESCALE_DIV = 16;
    localparam int unsigned NUM_CHARS = 8;
    localparam int unsigned NUM_COLS = 5;
    localparam int unsigned RAM_DEPTH = 56;
    localparam logic [2:0] NUM_ROWS = 3'h7;
    localparam logic [2:0] LAST_ROW = 3'h6;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [8:0] STAGE_LAST = 9'(STROBE_STAGES - 1);
    localparam logic [2:0] OP_ROW = 3'h0;
    localparam logic [2:0] OP_ADDR = 3'h5;
    localparam logic [2:0] OP_CTRL = 3'h7;
    localparam logic [7:0] CMD_CLEAR = 8'hC0;
    localparam int unsigned OPC_LSB = 5;
    localparam int unsigned PRESC_BIT = 4;
    localparam int unsigned PEAK_BIT = 3;
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [2:0] ADDR_RST = 3'h0;
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam int unsigned ST_CTRL_LSB = 0;
    localparam int unsigned ST_ADDR_LSB = 8;
    localparam int unsigned ST_WROW_LSB = 12;
    localparam int unsigned ST_ROW_LSB = 16;
    localparam int unsigned ST_CLR_BIT = 24;
    localparam int unsigned ST_WIPE_BIT = 25;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MX_IDLE = 2'h1,
        MX_FETCH = 2'h2
    } dmmcc_mx_t;

    function automatic logic [5:0] ram_index(input logic [2:0] ch, input logic [2:0] row);
        return 6'(ch * NUM_ROWS + row);
    endfunction

    // stage count during which the row strobe stays on
    function automatic logic [8:0] on_count(input logic [2:0] level);
        case (level)
            3'h0: return 9'h140;
            3'h1: return 9'h0AA;
            3'h2: return 9'h080;
            3'h3: return 9'h056;
            3'h4: return 9'h040;
            3'h5: return 9'h02A;
            3'h6: return 9'h015;
            default: return 9'h000;
        endcase
    endfunction
endpackage

/* verilog/dmmcc_div.sv */
`timescale 1ns/1ps
`default_nettype none
module dmmcc_div #(
    parameter int unsigned DIV = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_en,
    output logic o_tick
);
    localparam int unsigned W = (DIV > 2) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    if (DIV < 2) begin : g_bad_div
        $error("divider needs DIV of at least 2");
    end

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        o_tick = 1'b0;
        if (i_en) begin
            if (cnt_q == LAST) begin
                cnt_d = '0;
                o_tick = 1'b1;
            end else begin
                cnt_d = cnt_q + W'(1);
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule // dmmcc_div
`default_nettype wire

/* verilog/dmmcc_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module dmmcc_ram #(
    parameter int unsigned DEPTH = 56,
    parameter int unsigned WIDTH = 5
) (
    input wire logic i_ref_clk,
    input wire logic i_we,
    input wire logic [5:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic [5:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);
    if (DEPTH > 64 || DEPTH < 1) begin : g_bad_depth
        $error("memory depth must fit a 6-bit address");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rdata_q;

    // write and read ports are independent; read data is registered
    always_ff @(posedge i_ref_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        rdata_q <= mem[i_raddr];
    end

    assign o_rdata = rdata_q;
endmodule // dmmcc_ram
`default_nettype wire

/* verilog/dmmcc_top.sv */
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dmmcc_top
    import dmmcc_pkg::*;
#(
    parameter int unsigned OSC_DIV_P = OSC_DIV,
    parameter int unsigned ADDR_W = 4
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ser_data,
    input wire logic i_serial_shift_clock,
    input wire logic i_load_n,
    input wire logic i_int_osc_sel,
    input wire logic i_clk_io,
    output logic o_clk_io,
    output logic o_clk_io_oe,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic [6:0] o_row_strobe,
    output logic [39:0] o_col_data,
    output logic o_peak_full
);
    if (OSC_DIV_P < 2) begin : g_bad_osc
        $error("oscillator divider must be at least 2");
    end
    if (ADDR_W < 4) begin : g_bad_aw
        $error("address width must reach both registers");
    end

    // serial byte receiver
    logic sck_q, sck_d, load_q, load_d;
    logic [7:0] sh_q, sh_d;
    logic [3:0] bits_q, bits_d;
    logic ser_start, ser_done;

    always_comb begin
        sck_d = i_serial_shift_clock;
        load_d = i_load_n;
        sh_d = sh_q;
        bits_d = bits_q;
        ser_start = load_q & ~i_load_n;
        ser_done = ~load_q & i_load_n & (bits_q == BYTE_BITS);
        if (ser_start) begin
            bits_d = 4'h0;
        end else if (!i_load_n && i_serial_shift_clock && !sck_q && bits_q != BYTE_BITS) begin
            sh_d = {i_ser_data, sh_q[7:1]};
            bits_d = bits_q + 4'h1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            sck_q <= 1'b0;
            load_q <= 1'b1;
            sh_q <= 8'h00;
            bits_q <= 4'h0;
        end else begin
            sck_q <= sck_d;
            load_q <= load_d;
            sh_q <= sh_d;
            bits_q <= bits_d;
        end
    end

    // command decode, control word, address, memory wipe
    logic [4:0] ctrl_q, ctrl_d;
    logic [2:0] addr_q, addr_d;
    logic [2:0] wrow_q, wrow_d;
    logic clr_q, clr_d;
    logic wipe_q, wipe_d;
    logic [5:0] widx_q, widx_d;
    logic ram_we;
    logic [5:0] ram_wa;
    logic [4:0] ram_wd;
    logic wr_acc, cmd_hit, cmd_v;
    logic [7:0] cmd_b;

    // serial byte has priority; register writes wait in the cycle it completes or while a wipe is busy
    assign wr_acc = i_awvalid & i_wvalid & ~o_bvalid & ~wipe_q & ~ser_done;
    assign cmd_hit = wr_acc & (i_awaddr[3:0] == REG_CMD) & i_wstrb[0];
    assign cmd_v = ser_done | cmd_hit;
    assign cmd_b = ser_done ? sh_q : i_wdata[7:0];

    always_comb begin
        ctrl_d = ctrl_q;
        addr_d = addr_q;
        wrow_d = wrow_q;
        clr_d = clr_q;
        wipe_d = wipe_q;
        widx_d = widx_q;
        ram_we = 1'b0;
        ram_wa = widx_q;
        ram_wd = 5'h00;
        if (wipe_q) begin
            ram_we = 1'b1;
            if (widx_q == 6'(RAM_DEPTH - 1)) begin
                wipe_d = 1'b0;
            end else begin
                widx_d = widx_q + 6'h01;
            end
        end
        if (ser_start || cmd_hit) begin
            clr_d = 1'b0;
        end
        if (cmd_v && !wipe_q) begin
            if (cmd_b == CMD_CLEAR) begin
                addr_d = ADDR_RST;
                wrow_d = 3'h0;
                wipe_d = 1'b1;
                widx_d = 6'h00;
                clr_d = 1'b1;
            end else begin
                case (cmd_b[7:OPC_LSB])
                    OP_ADDR: begin
                        addr_d = cmd_b[2:0];
                        wrow_d = 3'h0;
                    end
                    OP_CTRL: begin
                        ctrl_d = cmd_b[4:0];
                    end
                    OP_ROW: begin
                        if (wrow_q < NUM_ROWS) begin
                            ram_we = 1'b1;
                            ram_wa = ram_index(addr_q, wrow_q);
                            ram_wd = cmd_b[4:0];
                            wrow_d = wrow_q + 3'h1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ctrl_q <= CTRL_RST;
            addr_q <= ADDR_RST;
            wrow_q <= 3'h0;
            clr_q <= 1'b0;
            wipe_q <= 1'b1;
            widx_q <= 6'h00;
        end else begin
            ctrl_q <= ctrl_d;
            addr_q <= addr_d;
            wrow_q <= wrow_d;
            clr_q <= clr_d;
            wipe_q <= wipe_d;
            widx_q <= widx_d;
        end
    end

    // strobe source clock selection and prescaler
    logic ext_q, ext_d, io_q, io_d;
    logic osc_tick, src_tick, pre_tick, mux_tick;

    dmmcc_div #(.DIV(OSC_DIV_P)) u_osc (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_en(1'b1),
        .o_tick(osc_tick)
    );

    assign src_tick = i_int_osc_sel ? osc_tick : (i_clk_io & ~ext_q);

    dmmcc_div #(.DIV(PRESCALE_DIV)) u_presc (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_en(src_tick & ctrl_q[PRESC_BIT]),
        .o_tick(pre_tick)
    );

    assign mux_tick = ctrl_q[PRESC_BIT] ? pre_tick : src_tick;

    always_comb begin
        ext_d = i_clk_io;
        io_d = osc_tick ? ~io_q : io_q;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ext_q <= 1'b0;
            io_q <= 1'b0;
        end else begin
            ext_q <= ext_d;
            io_q <= io_d;
        end
    end

    assign o_clk_io = io_q;
    assign o_clk_io_oe = i_int_osc_sel;

    // row multiplexer
    dmmcc_mx_t st_q, st_d;
    logic [8:0] stage_q, stage_d;
    logic [2:0] row_q, row_d, nrow;
    logic [3:0] fcnt_q, fcnt_d;
    logic [39:0] shadow_q, shadow_d, col_q, col_d;
    logic [6:0] strobe_q, strobe_d;
    logic [5:0] ram_ra;
    logic [4:0] ram_rd;

    dmmcc_ram #(.DEPTH(RAM_DEPTH), .WIDTH(NUM_COLS)) u_ram (
        .i_ref_clk(i_ref_clk),
        .i_we(ram_we),
        .i_waddr(ram_wa),
        .i_wdata(ram_wd),
        .i_raddr(ram_ra),
        .o_rdata(ram_rd)
    );

    assign nrow = (row_q == LAST_ROW) ? 3'h0 : row_q + 3'h1;
    assign ram_ra = ram_index(fcnt_q[2:0], nrow);

    always_comb begin
        st_d = st_q;
        stage_d = stage_q;
        row_d = row_q;
        fcnt_d = fcnt_q;
        shadow_d = shadow_q;
        col_d = col_q;
        case (st_q)
            MX_FETCH: begin
                // prefetch the next row of all characters
                for (int c = 0; c < NUM_CHARS; c++) begin
                    if (fcnt_q == 4'(c + 1)) begin
                        shadow_d[c*NUM_COLS +: NUM_COLS] = ram_rd;
                    end
                end
                fcnt_d = fcnt_q + 4'h1;
                if (fcnt_q == 4'(NUM_CHARS)) begin
                    st_d = MX_IDLE;
                end
            end
            MX_IDLE: begin
            end
            default: begin
                st_d = MX_IDLE;
            end
        endcase
        if (mux_tick) begin
            if (stage_q == STAGE_LAST) begin
                stage_d = 9'h000;
                row_d = nrow;
                col_d = shadow_q;
                st_d = MX_FETCH;
                fcnt_d = 4'h0;
            end else begin
                stage_d = stage_q + 9'h001;
            end
        end
        // rows fetched before or during a wipe must not reappear afterwards
        if (wipe_q) begin
            shadow_d = '0;
            col_d = '0;
        end
        strobe_d = 7'h00;
        if (stage_d < on_count(ctrl_q[2:0]) && !clr_q && !wipe_q) begin
            strobe_d = 7'h01 << row_d;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            st_q <= MX_FETCH;
            stage_q <= 9'h000;
            row_q <= 3'h0;
            fcnt_q <= 4'h0;
            shadow_q <= 40'h00_0000_0000;
            col_q <= 40'h00_0000_0000;
            strobe_q <= 7'h00;
        end else begin
            st_q <= st_d;
            stage_q <= stage_d;
            row_q <= row_d;
            fcnt_q <= fcnt_d;
            shadow_q <= shadow_d;
            col_q <= col_d;
            strobe_q <= strobe_d;
        end
    end

    assign o_row_strobe = strobe_q;
    assign o_col_data = col_q;
    assign o_peak_full = ctrl_q[PEAK_BIT];

    // register bus slave
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d, status;

    always_comb begin
        status = 32'h0000_0000;
        status[ST_CTRL_LSB +: 5] = ctrl_q;
        status[ST_ADDR_LSB +: 3] = addr_q;
        status[ST_WROW_LSB +: 3] = wrow_q;
        status[ST_ROW_LSB +: 3] = row_q;
        status[ST_CLR_BIT] = clr_q;
        status[ST_WIPE_BIT] = wipe_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (bvalid_q && i_bready) begin
            bvalid_d = 1'b0;
        end
        if (wr_acc) begin
            bvalid_d = 1'b1;
            bresp_d = (i_awaddr[3:0] == REG_CMD) ? RESP_OKAY : RESP_SLVERR;
        end
        if (rvalid_q && i_rready) begin
            rvalid_d = 1'b0;
        end
        if (i_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            rdata_d = 32'h0000_0000;
            case (i_araddr[3:0])
                REG_CMD: begin
                end
                REG_STATUS: begin
                    rdata_d = status;
                end
                default: begin
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else begin
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_awready = wr_acc;
    assign o_wready = wr_acc;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_arready = ~rvalid_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;
endmodule // dmmcc_top
`default_nettype wire

/* tb/dmmcc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module dmmcc_monitor
    import dmmcc_pkg::*;
#(
    parameter int unsigned ADDR_W = 4
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_int_osc_sel,
    input wire logic o_clk_io_oe,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic [1:0] o_bresp,
    input wire logic o_arready,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] o_rdata,
    input wire logic [6:0] o_row_strobe,
    input wire logic [39:0] o_col_data,
    input wire logic o_peak_full
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    wire logic take = i_awvalid && o_awready;
    wire logic cmd = take && i_awaddr == '0 && i_wstrb[0];
    wire logic clr = cmd && i_wdata[7:0] == CMD_CLEAR;
    oe_sel_a: assert property (o_clk_io_oe == i_int_osc_sel)
        else $error("pin enable wrong");
    rst_blank_a: assert property ($rose(i_rst_n) |-> !o_peak_full && o_row_strobe == 7'h00 && o_col_data == 40'h0)
        else $error("not blank after reset");
    one_row_a: assert property ($onehot0(o_row_strobe))
        else $error("several rows lit");
    row_next_a: assert property (o_row_strobe != 0 && $past(o_row_strobe) != 0 && $changed(o_row_strobe)
        |-> o_row_strobe == (($past(o_row_strobe) << 1) | ($past(o_row_strobe) >> 6))) else $error("row order");
    clr_blank_a: assert property (clr |-> ##3 (o_col_data == 40'h0) [*6])
        else $error("clear left columns lit");
    clr_keep_a: assert property (clr |=> $stable(o_peak_full) [*4])
        else $error("clear changed control word");
    peak_word_a: assert property (cmd && i_wdata[7:5] == 3'h7 |=> o_peak_full == $past(i_wdata[3]))
        else $error("peak bit not loaded");
    wr_resp_a: assert property (take |=> o_bvalid && o_bresp == ($past(i_awaddr) == '0 ? RESP_OKAY : RESP_SLVERR))
        else $error("write response wrong");
    b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped");
    ar_ready_a: assert property (o_arready == !o_rvalid)
        else $error("read ready wrong");
endmodule // dmmcc_monitor
bind dmmcc_top dmmcc_monitor #(.ADDR_W(ADDR_W)) u_mon (.i_ref_clk, .i_rst_n, .i_int_osc_sel, .o_clk_io_oe,
    .i_awvalid, .o_awready, .i_awaddr, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .o_arready,
    .o_rvalid, .i_rready, .o_rdata, .o_row_strobe, .o_col_data, .o_peak_full);
`default_nettype wire

/* tb/dmmcc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module dmmcc_host (
    input wire logic i_ref_clk,
    output logic o_ser_data,
    output logic o_shift_clk,
    output logic o_load_n
);
    initial begin
        o_ser_data = 1'b0;
        o_shift_clk = 1'b0;
        o_load_n = 1'b1;
    end
    task automatic open_cycle();
        o_load_n <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
    endtask
    // lsb first; load rise executes the byte
    task automatic shift_close(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            o_ser_data <= b[i];
            repeat (2) @(posedge i_ref_clk);
            o_shift_clk <= 1'b1;
            repeat (2) @(posedge i_ref_clk);
            o_shift_clk <= 1'b0;
        end
        repeat (2) @(posedge i_ref_clk);
        o_load_n <= 1'b1;
        o_ser_data <= ~b[7];
        repeat (3) @(posedge i_ref_clk);
    endtask
    task automatic send(input logic [7:0] b);
        open_cycle();
        shift_close(b);
    endtask
endmodule // dmmcc_host
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
    import dmmcc_pkg::*;
    localparam int OSC = 2;
    localparam int ROW = OSC * STROBE_STAGES;
    logic i_ref_clk, i_rst_n, i_int_osc_sel, ext_clk, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic [3:0] i_awaddr, i_araddr, i_wstrb;
    logic [31:0] i_wdata, rd_d;
    logic [1:0] rd_r;
    wire logic i_ser_data, i_serial_shift_clock, i_load_n, i_clk_io, o_clk_io, o_clk_io_oe;
    wire logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_peak_full;
    wire logic [1:0] o_bresp, o_rresp;
    wire logic [31:0] o_rdata;
    wire logic [6:0] o_row_strobe;
    wire logic [39:0] o_col_data;
    logic [4:0] pat [7] = '{5'h1E, 5'h11, 5'h11, 5'h11, 5'h11, 5'h11, 5'h1E};
    int num_errors = 0, n_tests = 0, cyc = 0, ext_half = 2, lit, on;
    // pin level: design drives it while enabled, else the external source
    assign i_clk_io = o_clk_io_oe ? o_clk_io : ext_clk;
    dmmcc_top #(.OSC_DIV_P(OSC)) uut (.i_ref_clk, .i_rst_n, .i_ser_data, .i_serial_shift_clock, .i_load_n,
        .i_int_osc_sel, .i_clk_io, .o_clk_io, .o_clk_io_oe, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid,
        .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready,
        .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .o_row_strobe, .o_col_data, .o_peak_full);
    dmmcc_host u_host (.i_ref_clk, .o_ser_data(i_ser_data), .o_shift_clk(i_serial_shift_clock), .o_load_n(i_load_n));
    initial begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        ext_clk = 1'b0;
        forever begin
            repeat (ext_half) @(posedge i_ref_clk);
            ext_clk <= ~ext_clk;
        end
    end
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 90000) begin
            num_errors++;
            print_verdict();
        end
    end
    task print_verdict();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // address 0x8 also stalls the response handshake
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge i_ref_clk);
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_awaddr <= a;
        i_wdata <= d;
        i_bready <= a != 4'h8;
        do @(posedge i_ref_clk); while (o_awready !== 1'b1);
        i_awvalid <= 1'b0;
        i_wvalid <= 1'b0;
        if (a == 4'h8) begin
            @(posedge i_ref_clk);
            i_bready <= 1'b1;
        end
        do @(posedge i_ref_clk); while (o_bvalid !== 1'b1);
        i_bready <= 1'b0;
        `CHK("bresp", er, o_bresp)
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge i_ref_clk);
        i_arvalid <= 1'b1;
        i_araddr <= a;
        i_rready <= a != 4'h8;
        do @(posedge i_ref_clk); while (o_arready !== 1'b1);
        i_arvalid <= 1'b0;
        if (a == 4'h8) begin
            @(posedge i_ref_clk);
            i_rready <= 1'b1;
        end
        do @(posedge i_ref_clk); while (o_rvalid !== 1'b1);
        i_rready <= 1'b0;
        rd_d = o_rdata;
        rd_r = o_rresp;
    endtask
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        rd(4'h4);
        `CHK("status", e, rd_d & m)
    endtask
    task automatic row_on(input int r);
        while (o_row_strobe[r] !== 1'b1) @(posedge i_ref_clk);
    endtask
    // cycles of one whole row, skipping the partial one
    task automatic period(input int e);
        logic [6:0] s;
        int n;
        s = o_row_strobe;
        while (o_row_strobe === s) @(posedge i_ref_clk);
        s = o_row_strobe;
        n = 0;
        while (o_row_strobe === s) begin
            @(posedge i_ref_clk);
            n++;
        end
        `CHK("period", e, n)
    endtask
    task automatic scan(input int n);
        lit = 0;
        on = 0;
        repeat (n) begin
            @(posedge i_ref_clk);
            if (o_col_data !== 40'h0) lit++;
            if (o_row_strobe !== 7'h00) on++;
        end
    endtask
    initial begin
        i_rst_n = 1'b0;
        i_int_osc_sel = 1'b1;
        i_awvalid = 1'b0;
        i_wvalid = 1'b0;
        i_bready = 1'b0;
        i_arvalid = 1'b0;
        i_rready = 1'b0;
        i_awaddr = 4'h0;
        i_araddr = 4'h0;
        i_wdata = 32'h0;
        i_wstrb = 4'hF;
        repeat (10) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        repeat (70) @(posedge i_ref_clk);
        st(32'h0300_771F, 32'h0);
        `CHK("peak", 1'b0, o_peak_full)
        rd(4'h8);
        `CHK("rresp", RESP_SLVERR, rd_r)
        `CHK("rdata", 32'h0, rd_d)
        wr(4'h4, 32'hE8, RESP_SLVERR);
        wr(4'h8, 32'hE8, RESP_SLVERR);
        u_host.send(8'hE8);
        st(32'h0000_771F, 32'h0000_0008);
        // command byte lane disabled: clear must be ignored
        i_wstrb <= 4'hE;
        wr(4'h0, 32'hC0, RESP_OKAY);
        i_wstrb <= 4'hF;
        st(32'h0100_771F, 32'h0000_0008);
        u_host.send(8'hA3);
        foreach (pat[i]) u_host.send({3'h0, pat[i]});
        u_host.send(8'h1F);
        st(32'h0000_771F, 32'h0000_7308);
        row_on(6);
        row_on(0);
        for (int r = 0; r < 7; r++) begin
            row_on(r);
            repeat (2) @(posedge i_ref_clk);
            `CHK("cols", 40'(pat[r]) << 15, o_col_data)
        end
        period(ROW);
        i_int_osc_sel <= 1'b0;
        period(4 * STROBE_STAGES);
        ext_half = 1;
        u_host.send(8'hF8);
        st(32'h1F, 32'h18);
        period(2 * PRESCALE_DIV * STROBE_STAGES);
        u_host.send(8'hE8);
        i_int_osc_sel <= 1'b1;
        period(ROW);
        wr(4'h0, 32'hC0, RESP_OKAY);
        st(32'h0100_771F, 32'h0100_0008);
        `CHK("peak", 1'b1, o_peak_full)
        scan(7 * ROW);
        `CHK("lit", 0, lit)
        st(32'h0100_0000, 32'h0100_0000);
        u_host.open_cycle();
        st(32'h0100_0000, 32'h0);
        u_host.shift_close(8'hEF);
        scan(7 * ROW);
        `CHK("dark", 0, on)
        `CHK("lit", 0, lit)
        wr(4'h0, 32'hE0, RESP_OKAY);
        scan(2 * ROW);
        `CHK("relit", 1'b1, on > ROW)
        `CHK("peak", 1'b0, o_peak_full)
        u_host.send(8'hEB);
        u_host.send(8'hA0);
        u_host.send(8'h1F);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        repeat (70) @(posedge i_ref_clk);
        st(32'h0000_771F, 32'h0);
        `CHK("peak", 1'b0, o_peak_full)
        scan(8 * ROW);
        `CHK("lit", 0, lit)
        period(ROW);
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
